/* ppsc_pkg.sv */
// ppsc_pkg: shared constants and pin bundles of the parallel printer port
// assumes a 10 MHz clock and a 32-bit classic wishbone register bus
package ppsc_pkg;

	// register byte offsets
	localparam logic [7:0] ADR_DATA = 8'h00;
	localparam logic [7:0] ADR_STAT = 8'h04;
	localparam logic [7:0] ADR_CTRL = 8'h08;
	localparam logic [7:0] ADR_PIN  = 8'h0C;
	localparam logic [7:0] ADR_IST  = 8'h10;
	localparam logic [7:0] ADR_IMSK = 8'h14;

	// status bit positions
	localparam int ST_BUSY = 7;
	localparam int ST_ACK  = 6;
	localparam int ST_PE   = 5;
	localparam int ST_SEL  = 4;
	localparam int ST_ERR  = 3;

	// control bit positions
	localparam int CT_DIR  = 5;
	localparam int CT_AIE  = 4;
	localparam int CT_SLIN = 3;
	localparam int CT_INIT = 2;
	localparam int CT_AFD  = 1;
	localparam int CT_STB  = 0;

	// interrupt bit positions
	localparam int IRQ_ACK = 0;
	localparam int IRQ_RDY = 1;

	// values after reset and access masks
	localparam logic [7:0] DATA_RST     = 8'h00;
	localparam logic [7:0] CTRL_RST     = 8'h04;
	localparam logic [7:0] CTRL_WR_MASK = 8'h3F;
	localparam logic [7:0] CTRL_RD_MASK = 8'h1F;
	localparam logic [1:0] IMSK_RST     = 2'h1;
	localparam logic [2:0] STAT_FILL    = 3'h0;

	// timing
	localparam int CLK_NS      = 100;
	localparam int STB_MIN_NS  = 500;
	localparam int SETUP_NS    = 500;
	localparam int HOLD_NS     = 500;
	localparam int INIT_MIN_NS = 50000;
	localparam logic [9:0] STB_MIN_CYC  = 10'((STB_MIN_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [9:0] SETUP_CYC    = 10'((SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [9:0] HOLD_CYC     = 10'((HOLD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [9:0] INIT_MIN_CYC = 10'((INIT_MIN_NS + CLK_NS - 1) / CLK_NS);

	typedef struct packed {
		logic busy;
		logic ack_n;
		logic paper_end;
		logic selected;
		logic error_n;
	} ppsc_prn_in_t;

	typedef struct packed {
		logic strobe_n;
		logic auto_fd_n;
		logic init_n;
		logic select_in_n;
	} ppsc_prn_out_t;

endpackage

/* ppsc_min_pulse.sv */
// ppsc_min_pulse: level follower that, once active, stays active a minimum
// number of cycles; activation also waits for a permission input
`timescale 1ns/1ps
`default_nettype none
module ppsc_min_pulse #(
	parameter logic [9:0] MIN_CYC = 10'h005
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic req,
	input  wire logic start_ok,
	output logic      act
);
	logic [9:0] cnt;
	logic       next_act;
	logic [9:0] next_cnt;

	wire start = ~act & req & start_ok;
	wire stop  = act & ~req & (cnt >= MIN_CYC);

	assign next_act = start ? 1'b1 : (stop ? 1'b0 : act);
	assign next_cnt = start ? 10'h001 :
		((act && cnt < MIN_CYC) ? 10'(cnt + 10'h001) : cnt);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			act <= 1'b0;
			cnt <= 10'h000;
		end else if (ce) begin
			act <= next_act;
			cnt <= next_cnt;
		end
	end

	pulse_width_a: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(act) |-> $past(cnt) >= MIN_CYC)
		else $error("pulse ended before its minimum width");

endmodule // ppsc_min_pulse
`default_nettype wire

/* ppsc_top.sv */
// ppsc_top: parallel printer port with control and data latches and a live status word
// behind a classic wishbone slave; printer pins are synchronous to clk
// Function
// - software reads back the output data latch at its own address.
// - status bit 7 shows the printer busy line, and busy means no new byte; data writes and the strobe do not wait for busy.
// - status bit 6 shows the live acknowledge line level.
// - status bit 5 reads one when the printer is out of paper.
// - status bit 4 reads one when the printer is selected.
// - status bit 3 reads zero when the printer reports an error.
// - software reads back the control latch at its own address.
// - control bit 5, write only, turns the data drivers off when one.
// - with control bit 4 set, each rising acknowledge edge interrupts.
// - control bit 3 at one asserts select-in toward the printer.
// - control bit 2 at zero drives initialize, for at least 50 us.
// - control bit 1 at one asserts auto line-feed.
// - control bit 0 drives the strobe, at least 0.5 us wide.
// - data is stable 0.5 us before and after the strobe pulse.
// - the port presents eight parallel data lines.
//
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ppsc_top (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   ce,
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [7:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	output logic                        irq,
	output logic      [7:0]             pd_o,
	output logic                        pd_oe,
	input  wire logic [7:0]             pd_i,
	input  wire ppsc_pkg::ppsc_prn_in_t prn_in,
	output ppsc_pkg::ppsc_prn_out_t     prn_out
);

	function automatic logic adr_hit(input logic [7:0] adr,
		input logic [7:0] off);
		return adr[7:2] == off[7:2];
	endfunction

	// reset release through two flops
	logic rst_meta;
	logic rst_sync;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else if (ce) begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// state
	logic [7:0] data_lat;
	logic [7:0] ctrl_lat;
	logic [1:0] irq_pend;
	logic [1:0] irq_mask;
	logic       ack_last;
	logic       busy_last;
	logic [9:0] setup_cnt;
	logic [9:0] hold_cnt;
	logic       stb_act;
	logic       init_act;

	// bus decode
	wire hit_data = adr_hit(wb_adr_i, ppsc_pkg::ADR_DATA);
	wire hit_stat = adr_hit(wb_adr_i, ppsc_pkg::ADR_STAT);
	wire hit_ctrl = adr_hit(wb_adr_i, ppsc_pkg::ADR_CTRL);
	wire hit_pin  = adr_hit(wb_adr_i, ppsc_pkg::ADR_PIN);
	wire hit_ist  = adr_hit(wb_adr_i, ppsc_pkg::ADR_IST);
	wire hit_imsk = adr_hit(wb_adr_i, ppsc_pkg::ADR_IMSK);

	wire setup_done = (setup_cnt == ppsc_pkg::SETUP_CYC);
	wire hold_done  = (hold_cnt == ppsc_pkg::HOLD_CYC);
	// a data write waits out the strobe and its hold time, so the byte
	// on the pins never moves under a pulse
	wire data_busy  = stb_act | ~hold_done;

	wire bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire stall    = hit_data & wb_we_i & data_busy;
	wire accept   = ce & bus_req & ~stall;
	wire wr       = accept & wb_we_i & wb_sel_i[0];
	wire rd       = accept & ~wb_we_i;
	wire wr_data  = wr & hit_data;
	wire wr_ctrl  = wr & hit_ctrl;
	wire wr_ist   = wr & hit_ist;
	wire wr_imsk  = wr & hit_imsk;

	// status word, bits 2..0 not used and fixed
	wire [7:0] stat_word = {prn_in.busy,
		prn_in.ack_n,
		prn_in.paper_end,
		prn_in.selected,
		prn_in.error_n,
		ppsc_pkg::STAT_FILL};

	// direction bit is write only and reads back as zero
	wire [7:0] ctrl_rd = ctrl_lat & ppsc_pkg::CTRL_RD_MASK;

	wire [31:0] rd_word =
		hit_data ? {24'h000000, data_lat} :
		hit_stat ? {24'h000000, stat_word} :
		hit_ctrl ? {24'h000000, ctrl_rd} :
		hit_pin  ? {24'h000000, pd_i} :
		hit_ist  ? {30'h00000000, irq_pend} :
		hit_imsk ? {30'h00000000, irq_mask} :
		32'h00000000;

	// printer events
	wire       ack_rise  = ~ack_last & prn_in.ack_n;
	wire       busy_fall = busy_last & ~prn_in.busy;
	wire [1:0] irq_ev    = {busy_fall, ack_rise & ctrl_lat[ppsc_pkg::CT_AIE]};
	wire [1:0] irq_clr   = wr_ist ? wb_dat_i[1:0] : 2'h0;
	// a new event beats a clear in the same cycle
	wire [1:0] next_irq_pend = (irq_pend & ~irq_clr) | irq_ev;

	wire [9:0] next_setup_cnt = wr_data ? 10'h000 :
		(setup_done ? setup_cnt : 10'(setup_cnt + 10'h001));
	wire [9:0] next_hold_cnt = stb_act ? 10'h000 :
		(hold_done ? hold_cnt : 10'(hold_cnt + 10'h001));

	// wishbone answer
	always_ff @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else if (ce) begin
			wb_ack_o <= accept;
			if (accept)
				wb_dat_o <= rd ? rd_word : 32'h00000000;
		end
	end

	// software latches
	always_ff @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			data_lat <= ppsc_pkg::DATA_RST;
			ctrl_lat <= ppsc_pkg::CTRL_RST;
			irq_mask <= ppsc_pkg::IMSK_RST;
		end else if (ce) begin
			if (wr_data)
				data_lat <= wb_dat_i[7:0];
			if (wr_ctrl)
				ctrl_lat <= wb_dat_i[7:0] & ppsc_pkg::CTRL_WR_MASK;
			if (wr_imsk)
				irq_mask <= wb_dat_i[1:0];
		end
	end

	// event capture and pulse timing
	always_ff @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			irq_pend  <= 2'h0;
			ack_last  <= 1'b1;
			busy_last <= 1'b0;
			setup_cnt <= ppsc_pkg::SETUP_CYC;
			hold_cnt  <= ppsc_pkg::HOLD_CYC;
		end else if (ce) begin
			irq_pend  <= next_irq_pend;
			ack_last  <= prn_in.ack_n;
			busy_last <= prn_in.busy;
			setup_cnt <= next_setup_cnt;
			hold_cnt  <= next_hold_cnt;
		end
	end

	// strobe waits for data setup, then lasts its minimum width
	ppsc_min_pulse #(
		.MIN_CYC (ppsc_pkg::STB_MIN_CYC)
	) u_strobe (
		.clk      (clk),
		.rst_n    (rst_sync),
		.ce       (ce),
		.req      (ctrl_lat[ppsc_pkg::CT_STB]),
		// a data write landing in the same cycle holds the strobe back
		.start_ok (setup_done & ~wr_data),
		.act      (stb_act)
	);

	// initialize is stretched so a short software pulse is still valid
	ppsc_min_pulse #(
		.MIN_CYC (ppsc_pkg::INIT_MIN_CYC)
	) u_init (
		.clk      (clk),
		.rst_n    (rst_sync),
		.ce       (ce),
		.req      (~ctrl_lat[ppsc_pkg::CT_INIT]),
		.start_ok (1'b1),
		.act      (init_act)
	);

	// pins
	assign pd_o                = data_lat;
	assign pd_oe               = ~ctrl_lat[ppsc_pkg::CT_DIR];
	assign prn_out.strobe_n    = ~stb_act;
	assign prn_out.auto_fd_n   = ~ctrl_lat[ppsc_pkg::CT_AFD];
	assign prn_out.init_n      = ~init_act;
	assign prn_out.select_in_n = ~ctrl_lat[ppsc_pkg::CT_SLIN];
	assign irq                 = |(irq_pend & irq_mask);

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync);

	sequence s_rd_stat;
		rd && hit_stat;
	endsequence

	sequence s_rd_data;
		rd && hit_data;
	endsequence

	sequence s_rd_ctrl;
		rd && hit_ctrl;
	endsequence

	data_readback_a: assert property (
		s_rd_data |=> wb_dat_o == {24'h000000, $past(data_lat)})
		else $error("data read-back differs from latch");

	busy_status_a: assert property (
		s_rd_stat |=> wb_dat_o[ppsc_pkg::ST_BUSY] == $past(prn_in.busy))
		else $error("busy status bit wrong");

	ack_status_a: assert property (
		s_rd_stat |=> wb_dat_o[ppsc_pkg::ST_ACK] == $past(prn_in.ack_n))
		else $error("acknowledge status bit wrong");

	paper_status_a: assert property (
		s_rd_stat |=> wb_dat_o[ppsc_pkg::ST_PE] == $past(prn_in.paper_end))
		else $error("paper-end status bit wrong");

	select_status_a: assert property (
		s_rd_stat |=> wb_dat_o[ppsc_pkg::ST_SEL] == $past(prn_in.selected))
		else $error("selected status bit wrong");

	error_status_a: assert property (
		s_rd_stat |=> wb_dat_o[ppsc_pkg::ST_ERR] == $past(prn_in.error_n))
		else $error("error status bit wrong");

	stat_fill_a: assert property (
		s_rd_stat |=> wb_dat_o[2:0] == 3'h0 && wb_dat_o[31:8] == 24'h000000)
		else $error("unused status bits not fixed");

	ctrl_readback_a: assert property (
		s_rd_ctrl |=> wb_dat_o[4:0] == $past(ctrl_lat[4:0])
			&& wb_dat_o[31:5] == 27'h0000000)
		else $error("control read-back wrong");

	dir_drive_a: assert property (
		(wr_ctrl && wb_dat_i[ppsc_pkg::CT_DIR]) |=> !pd_oe)
		else $error("data drivers still on after direction set");

	ack_irq_a: assert property (
		(ce && ctrl_lat[ppsc_pkg::CT_AIE] && ack_rise && irq_mask[0])
			|=> irq_pend[ppsc_pkg::IRQ_ACK] && irq)
		else $error("acknowledge edge gave no interrupt");

	select_pin_a: assert property (
		wr_ctrl |=> prn_out.select_in_n == !$past(wb_dat_i[ppsc_pkg::CT_SLIN]))
		else $error("select-in pin does not follow control bit");

	init_start_a: assert property (
		(wr_ctrl && !wb_dat_i[ppsc_pkg::CT_INIT] && !init_act && ce)
			|=> ##1 !prn_out.init_n)
		else $error("initialize not driven after write of zero");

	afd_pin_a: assert property (
		wr_ctrl |=> prn_out.auto_fd_n == !$past(wb_dat_i[ppsc_pkg::CT_AFD]))
		else $error("auto line-feed pin does not follow control bit");

	strobe_setup_a: assert property (
		$rose(stb_act) |-> $past(setup_done) && $stable(data_lat))
		else $error("strobe began before data setup");

	data_hold_a: assert property (
		wr_data |-> !stb_act && hold_done)
		else $error("data changed during strobe or hold");

	// strobe steps: a request with setup met starts it, then it stands
	sequence s_stb_start;
		ce && !stb_act && ctrl_lat[ppsc_pkg::CT_STB]
			&& setup_done && !wr_data;
	endsequence

	sequence s_stb_width;
		stb_act [*5];
	endsequence

	strobe_start_a: assert property (
		s_stb_start |=> stb_act)
		else $error("strobe did not start after its request");

	strobe_width_a: assert property (
		$rose(stb_act) |-> s_stb_width)
		else $error("strobe shorter than its minimum");

	strobe_release_a: assert property (
		$fell(stb_act) |-> !$past(ctrl_lat[ppsc_pkg::CT_STB]))
		else $error("strobe ended while still requested");

	data_steady_a: assert property (
		stb_act |-> $stable(pd_o))
		else $error("data lines moved under the strobe");

	hold_steady_a: assert property (
		!hold_done |-> $stable(pd_o))
		else $error("data lines moved inside the hold time");

	init_req_a: assert property (
		(ce && !ctrl_lat[ppsc_pkg::CT_INIT] && !init_act) |=> init_act)
		else $error("initialize request not started");

	init_release_a: assert property (
		$fell(init_act) |-> $past(ctrl_lat[ppsc_pkg::CT_INIT]))
		else $error("initialize ended while still requested");

	irq_clear_a: assert property (
		(wr_ist && wb_dat_i[ppsc_pkg::IRQ_ACK]
			&& !irq_ev[ppsc_pkg::IRQ_ACK]) |=> !irq_pend[ppsc_pkg::IRQ_ACK])
		else $error("pending acknowledge bit not cleared");

	event_wins_a: assert property (
		(ce && irq_ev[ppsc_pkg::IRQ_ACK]) |=> irq_pend[ppsc_pkg::IRQ_ACK])
		else $error("acknowledge event lost");

	dir_release_a: assert property (
		(wr_ctrl && !wb_dat_i[ppsc_pkg::CT_DIR]) |=> pd_oe)
		else $error("data drivers not back on after direction cleared");

	data_write_a: assert property (
		wr_data |=> data_lat == $past(wb_dat_i[7:0]))
		else $error("data latch missed a write");

	ctrl_mask_a: assert property (
		wr_ctrl |=> ctrl_lat[7:6] == 2'h0)
		else $error("undefined control bits stored");

	unmapped_zero_a: assert property (
		(rd && !(hit_data || hit_stat || hit_ctrl || hit_pin || hit_ist
			|| hit_imsk)) |=> wb_dat_o == 32'h00000000)
		else $error("unmapped read not zero");

endmodule // ppsc_top
`default_nettype wire

/* ppsc_prn_model.sv */
// ppsc_prn_model: behavioural printer at the far side of the port
// assumes pins sampled on clk and that the bench sets the static lines
`timescale 1ns/1ps
`default_nettype none
module ppsc_prn_model (
	input  wire logic                    clk,
	input  wire ppsc_pkg::ppsc_prn_out_t prn_out,
	input  wire logic                    pe,
	input  wire logic                    sel,
	input  wire logic                    err_n,
	output ppsc_pkg::ppsc_prn_in_t       prn_in
);
	logic [6:0] cnt = 7'h00;
	logic       stb_q = 1'b1;
	logic       bsy;
	logic       ack_lo;
	// a strobe fall takes the byte; busy drops two cycles before the acknowledge ends
	always_ff @(posedge clk) begin
		stb_q <= prn_out.strobe_n;
		if (stb_q && !prn_out.strobe_n)
			cnt <= 7'h01;
		else if (cnt != 7'h00 && cnt < 7'h3C)
			cnt <= cnt + 7'h01;
		else
			cnt <= 7'h00;
	end
	assign bsy    = cnt != 7'h00 && cnt < 7'h3B;
	// acknowledge low 51 cycles, rising two cycles after busy ends
	assign ack_lo = cnt >= 7'h0A;
	assign prn_in = {bsy, !ack_lo, pe, sel, err_n};
endmodule // ppsc_prn_model
`default_nettype wire

/* tb_top.sv */
// tb_top: self-checking bench of the printer port over wishbone
// assumes the printer model file and the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
	$display("mismatch at %0t: got %h want %h", $time, a, b); end end
module tb_top;
	logic                    clk = 0, rst_n = 0, cyc = 0, we = 0;
	logic [7:0]              adr = 0, pd_o, pd_x = 8'h5A;
	logic [31:0]             wdat = 0, rdat, dat_o;
	logic                    ack, irq, pd_oe, pe = 0, sel = 1, err_n = 1;
	ppsc_pkg::ppsc_prn_in_t  prn_in;
	ppsc_pkg::ppsc_prn_out_t prn_out;
	int                      mismatches = 0, tests_run = 0, cyc_cnt = 0;
	int                      t_pd = 0, t_st = -1000, t_fl = 0;
	ppsc_top i_ppsc_top (.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .irq(irq), .pd_o(pd_o), .pd_oe(pd_oe),
		.pd_i(pd_oe ? pd_o : pd_x), .prn_in(prn_in), .prn_out(prn_out));
	ppsc_prn_model i_ppsc_prn_model (.clk(clk), .prn_out(prn_out),
		.pe(pe), .sel(sel), .err_n(err_n), .prn_in(prn_in));
	initial begin
		forever #50 clk = ~clk;
	end
	// strobe width and data setup and hold watched on every pulse
	always @(negedge prn_out.strobe_n) if (rst_n) begin
		t_fl = int'($time);
		`CHK(t_fl - t_pd >= 500, 1'b1);
	end
	always @(posedge prn_out.strobe_n) if (rst_n) begin
		t_st = int'($time);
		`CHK(t_st - t_fl >= 500, 1'b1);
	end
	always @(pd_o) if (rst_n) begin
		t_pd = int'($time);
		`CHK(prn_out.strobe_n && t_pd - t_st >= 500, 1'b1);
	end
	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("compares %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// one classic cycle; waits for ack, then one idle edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 200);
		if (ack !== 1'b1) begin
			mismatches++;
			$display("mismatch at %0t: no bus answer", $time);
		end
		rdat = dat_o;
		cyc <= 1'b0;
		we  <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		xfer(1'b0, a, 32'h0);
		`CHK(rdat[7:0], exp);
	endtask
	// 0 strobe pin, 1 acknowledge line, 2 interrupt output
	function automatic logic probe(input int k);
		return k == 0 ? prn_out.strobe_n : (k == 1 ? prn_in.ack_n : irq);
	endfunction
	task automatic wait_for(input int k, input logic v);
		int n;
		n = 0;
		while (probe(k) !== v && n < 300) begin
			@(posedge clk);
			n++;
		end
		if (probe(k) !== v) begin
			mismatches++;
			$display("mismatch at %0t: wait ran out", $time);
		end
	endtask
	task automatic t_reset();
		rd(ppsc_pkg::ADR_DATA, 8'h00);
		rd(ppsc_pkg::ADR_CTRL, 8'h04);
		rd(ppsc_pkg::ADR_IMSK, 8'h01);
		`CHK(prn_out, 4'hF);
		`CHK(pd_oe, 1'b1);
		$display("test reset done");
	endtask
	task automatic t_data();
		xfer(1'b1, ppsc_pkg::ADR_DATA, 32'hFFFF_FFA5);
		rd(ppsc_pkg::ADR_DATA, 8'hA5);
		`CHK(pd_o, 8'hA5);
		rd(8'h20, 8'h00);
		$display("test data done");
	endtask
	task automatic t_ctrl();
		xfer(1'b1, ppsc_pkg::ADR_CTRL, 32'h0A);
		rd(ppsc_pkg::ADR_CTRL, 8'h0A);
		`CHK(prn_out, 4'b1000);
		xfer(1'b1, ppsc_pkg::ADR_CTRL, 32'h04);
		`CHK(prn_out, 4'b1101);
		repeat (500) @(posedge clk);
		`CHK(prn_out, 4'hF);
		$display("test control done");
	endtask
	task automatic t_dir();
		xfer(1'b1, ppsc_pkg::ADR_CTRL, 32'hE4);
		rd(ppsc_pkg::ADR_CTRL, 8'h04);
		`CHK(pd_oe, 1'b0);
		rd(ppsc_pkg::ADR_PIN, 8'h5A);
		xfer(1'b1, ppsc_pkg::ADR_CTRL, 32'h04);
		`CHK(pd_oe, 1'b1);
		$display("test direction done");
	endtask
	task automatic t_status();
		pe    <= 1'b1;
		err_n <= 1'b0;
		@(posedge clk);
		rd(ppsc_pkg::ADR_STAT, 8'h70);
		pe    <= 1'b0;
		sel   <= 1'b0;
		err_n <= 1'b1;
		@(posedge clk);
		rd(ppsc_pkg::ADR_STAT, 8'h48);
		$display("test status done");
	endtask
	task automatic t_strobe();
		xfer(1'b1, ppsc_pkg::ADR_CTRL, 32'h14);
		xfer(1'b1, ppsc_pkg::ADR_DATA, 32'h3C);
		xfer(1'b1, ppsc_pkg::ADR_CTRL, 32'h15);
		wait_for(0, 1'b0);
		`CHK(pd_o, 8'h3C);
		xfer(1'b1, ppsc_pkg::ADR_CTRL, 32'h14);
		xfer(1'b1, ppsc_pkg::ADR_DATA, 32'hC3);
		rd(ppsc_pkg::ADR_DATA, 8'hC3);
		wait_for(1, 1'b0);
		rd(ppsc_pkg::ADR_STAT, 8'h88);
		wait_for(2, 1'b1);
		`CHK(irq, 1'b1);
		rd(ppsc_pkg::ADR_IST, 8'h03);
		xfer(1'b1, ppsc_pkg::ADR_IST, 32'h1);
		`CHK(irq, 1'b0);
		xfer(1'b1, ppsc_pkg::ADR_IST, 32'h2);
		rd(ppsc_pkg::ADR_IST, 8'h00);
		$display("test strobe done");
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_data();
		t_ctrl();
		t_dir();
		t_status();
		t_strobe();
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
